// >>> hdl/vd_pkg.sv
package vd_pkg;

  // ------------------------------------------------------------------
  // register map, byte addresses on the register bus
  // ------------------------------------------------------------------
  localparam int          ADDR_W             = 8;
  localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
  localparam logic [7:0]  INT_STATUS_OFFSET  = 8'h04;
  localparam logic [7:0]  INT_MASK_OFFSET    = 8'h08;

  // ------------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------------
  localparam int          EN_BIT             = 15;
  localparam int          SIDL_BIT           = 13;
  localparam int          DIR_BIT            = 11;
  localparam int          RSV_A_BIT          = 10;
  localparam int          RSV_B_BIT          = 9;
  localparam int          LIVE_BIT           = 8;
  localparam int          LIMIT_LSB          = 0;
  localparam int          LIMIT_W            = 4;
  localparam int          CTRL_W             = 16;

  // ------------------------------------------------------------------
  // limit codes
  // ------------------------------------------------------------------
  localparam logic [3:0]  LIMIT_EXTERNAL     = 4'hF;
  localparam logic [3:0]  LIMIT_LOWEST_INT   = 4'hE;
  localparam logic [3:0]  LIMIT_HIGHEST_INT  = 4'h5;
  localparam logic [3:0]  LIMIT_RESET        = 4'h0;

  // ------------------------------------------------------------------
  // interrupt status / mask layout and reset values
  // ------------------------------------------------------------------
  localparam int          INT_DETECT_BIT     = 0;
  localparam int          INT_READY_BIT      = 1;
  localparam int          INT_W              = 2;
  localparam logic [1:0]  INT_STATUS_RESET   = 2'h1;
  localparam logic [1:0]  INT_MASK_RESET     = 2'h0;

  // ------------------------------------------------------------------
  // bus responses
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS      = 25;
  localparam int          SETTLE_TIME_NS     = 5000;
  localparam int          SETTLE_CYCLES_I    =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SETTLE_W           = 8;
  localparam logic [7:0]  SETTLE_CYCLES      = SETTLE_CYCLES_I[7:0];

  // software-held configuration
  typedef struct packed {
    logic       enable;
    logic       stop_in_idle;
    logic       dir_up;
    logic [3:0] limit;
  } vd_ctrl_s;

  // drive towards the analog comparator and reference
  typedef struct packed {
    logic       power;
    logic       ext_select;
    logic [3:0] level;
  } vd_analog_s;

endpackage

// >>> hdl/vd_event_qual.sv
`timescale 1ns/10ps
`default_nettype none

module vd_event_qual
(
  input  wire logic             sys_clk_in,   // system clock
  input  wire logic             rst_in,       // sync reset, high
  input  wire vd_pkg::vd_ctrl_s ctrl_in,      // configuration
  input  wire logic             idle_mode_in, // device in idle
  input  wire logic             above_in,     // supply at or above trip
  input  wire logic             below_in,     // supply at or below trip
  output logic                  active_out,   // detector powered and running
  output logic                  live_out,     // live event status
  output logic                  ready_out     // one-cycle pulse, settling done
);

  logic                         code_ok;
  logic                         running;
  logic [vd_pkg::SETTLE_W-1:0]  settle_cnt;
  logic                         settled;

  // --------------------------------------------------------------
  // qualification
  // --------------------------------------------------------------
  // reserved limit codes never produce events
  assign code_ok = (ctrl_in.limit >= vd_pkg::LIMIT_HIGHEST_INT);
  // idle stop and power enable
  assign running = ctrl_in.enable
                   && !(ctrl_in.stop_in_idle && idle_mode_in)
                   && code_ok;
  assign active_out = running;

  // --------------------------------------------------------------
  // warm-up counter
  // --------------------------------------------------------------
  // results ignored until the analog side has settled
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !running)
    begin
      settle_cnt <= '0;
      settled    <= 1'b0;
      ready_out  <= 1'b0;
    end
    else if (!settled)
    begin
      settle_cnt <= settle_cnt + 8'h01;
      settled    <= (settle_cnt == vd_pkg::SETTLE_CYCLES - 8'h01);
      ready_out  <= (settle_cnt == vd_pkg::SETTLE_CYCLES - 8'h01);
    end
    else
    begin
      ready_out  <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // live event, by direction
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      live_out <= 1'b0;
    else
      live_out <= running && settled
                  && (ctrl_in.dir_up ? above_in : below_in);
  end

endmodule

`default_nettype wire

// >>> hdl/vd_detect_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - the detect flag sets when the supply passes the trip point in the chosen direction, and an unmasked flag raises the interrupt.
// - the detect flag may already be set after power-on reset, so software clears it before first use.
// - control bit 15 powers the detector when one, holds it off and inactive when zero, and resets to zero.
// - control bit 13 set stops the detector in idle mode, clear keeps it running in idle.
// - control bit 11 one means event at or above the trip point, zero means at or below.
// - control bits 10 and 9 always read as one whatever is written.
// - status bit 8 is hardware driven and reads one exactly while the detection condition holds.
// - limit code 1111 selects the external input compared against the band gap.
// - limit codes 1110 to 0101 pick ten internal levels, codes 0100 to 0000 must not be used.
// - a write clearing the detect flag has no effect while the live status reads one.
// - control bits 14, 12 and 7 to 4 ignore writes and read as zero.
module vd_detect_ctrl
(
  input  wire logic                      sys_clk_in,         // 40 MHz system clock
  input  wire logic                      rst_in,             // sync reset, high
  // axi4-lite write address
  input  wire logic [vd_pkg::ADDR_W-1:0] s_axi_awaddr_in,    // write address
  input  wire logic                      s_axi_awvalid_in,   // write address valid
  output logic                           s_axi_awready_out,  // write address ready
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata_in,     // write data
  input  wire logic [3:0]                s_axi_wstrb_in,     // byte strobes
  input  wire logic                      s_axi_wvalid_in,    // write data valid
  output logic                           s_axi_wready_out,   // write data ready
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp_out,    // write response
  output logic                           s_axi_bvalid_out,   // response valid
  input  wire logic                      s_axi_bready_in,    // response ready
  // axi4-lite read address
  input  wire logic [vd_pkg::ADDR_W-1:0] s_axi_araddr_in,    // read address
  input  wire logic                      s_axi_arvalid_in,   // read address valid
  output logic                           s_axi_arready_out,  // read address ready
  // axi4-lite read data
  output logic [31:0]                    s_axi_rdata_out,    // read data
  output logic [1:0]                     s_axi_rresp_out,    // read response
  output logic                           s_axi_rvalid_out,   // read data valid
  input  wire logic                      s_axi_rready_in,    // read data ready
  // device and analog side
  input  wire logic                      idle_mode_in,       // device in idle mode
  input  wire logic                      supply_above_in,    // at or above trip
  input  wire logic                      supply_below_in,    // at or below trip
  output vd_pkg::vd_analog_s             analog_ctrl_out,    // comparator setup
  output logic                           live_event_out,     // live event status
  output logic                           irq_out             // level interrupt
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  // detector state
  vd_pkg::vd_ctrl_s                      ctrl;
  logic [vd_pkg::INT_W-1:0]              int_status;
  logic [vd_pkg::INT_W-1:0]              int_mask;
  logic                                  active;
  logic                                  live;
  logic                                  ready_pulse;

  // write capture and decode
  logic                                  aw_held;
  logic [vd_pkg::ADDR_W-1:0]             aw_addr;
  logic                                  w_held;
  logic [31:0]                           w_data;
  logic [3:0]                            w_strb;
  logic                                  wr_fire;
  logic                                  wr_ctrl;
  logic                                  wr_status;
  logic                                  wr_mask;
  logic                                  wr_known;

  // read path
  logic [vd_pkg::CTRL_W-1:0]             ctrl_rd;
  logic [31:0]                           next_rdata;
  logic [1:0]                            next_rresp;

  // clear strobes for the flags
  logic                                  clr_detect;
  logic                                  clr_ready;

  // ------------------------------------------------------------------
  // event qualifier
  // ------------------------------------------------------------------
  // gates by power, idle stop, code and warm-up
  vd_event_qual u_qual
  (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .ctrl_in      (ctrl),
    .idle_mode_in (idle_mode_in),
    .above_in     (supply_above_in),
    .below_in     (supply_below_in),
    .active_out   (active),
    .live_out     (live),
    .ready_out    (ready_pulse)
  );

  // ------------------------------------------------------------------
  // analog side drive
  // ------------------------------------------------------------------
  // power follows enable and idle stop, held off for reserved limit codes
  // trails the control register by one cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      analog_ctrl_out <= '0;
    end
    else
    begin
      analog_ctrl_out.power      <= active;
      analog_ctrl_out.ext_select <= (ctrl.limit == vd_pkg::LIMIT_EXTERNAL);
      analog_ctrl_out.level      <= ctrl.limit;
    end
  end

  // live status straight from the qualifier flop
  // same flop feeds the control readback
  assign live_event_out = live;

  // ------------------------------------------------------------------
  // write address / data capture
  // ------------------------------------------------------------------
  // each channel is taken on its own and held until the response
  // readies drop while a response waits, one write in flight
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end
    else if (wr_fire)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end
    else if (wr_fire)
    begin
      w_held <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  // fires once both halves are held
  assign wr_fire   = aw_held && w_held && !s_axi_bvalid_out;
  assign wr_ctrl   = wr_fire && (aw_addr == vd_pkg::CTRL_OFFSET);
  assign wr_status = wr_fire && (aw_addr == vd_pkg::INT_STATUS_OFFSET);
  assign wr_mask   = wr_fire && (aw_addr == vd_pkg::INT_MASK_OFFSET);
  assign wr_known  = wr_ctrl || wr_status || wr_mask;

  // write response, error on unmapped address
  // bvalid holds until bready
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= vd_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_known ? vd_pkg::RESP_OKAY : vd_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------
  // only enable, idle stop, direction and limit hold state
  // reserved bits are rebuilt on read
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ctrl.enable       <= 1'b0;
      ctrl.stop_in_idle <= 1'b0;
      ctrl.dir_up       <= 1'b0;
      ctrl.limit        <= vd_pkg::LIMIT_RESET;
    end
    else if (wr_ctrl)
    begin
      // lane one: enable, idle stop, direction
      if (w_strb[1])
      begin
        ctrl.enable       <= w_data[vd_pkg::EN_BIT];
        ctrl.stop_in_idle <= w_data[vd_pkg::SIDL_BIT];
        ctrl.dir_up       <= w_data[vd_pkg::DIR_BIT];
      end
      // lane zero: limit code
      if (w_strb[0])
      begin
        ctrl.limit <= w_data[vd_pkg::LIMIT_LSB +: vd_pkg::LIMIT_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------------
  // detect clear refused while the event is live
  assign clr_detect = wr_status && w_strb[0] && w_data[vd_pkg::INT_DETECT_BIT]
                      && !live;
  // ready event clears freely
  assign clr_ready  = wr_status && w_strb[0] && w_data[vd_pkg::INT_READY_BIT];

  // sticky flags, set wins over clear
  // so an event is never lost to a clear
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      int_status <= vd_pkg::INT_STATUS_RESET;
    end
    else
    begin
      if (live)
        int_status[vd_pkg::INT_DETECT_BIT] <= 1'b1;
      else if (clr_detect)
        int_status[vd_pkg::INT_DETECT_BIT] <= 1'b0;
      if (ready_pulse)
        int_status[vd_pkg::INT_READY_BIT] <= 1'b1;
      else if (clr_ready)
        int_status[vd_pkg::INT_READY_BIT] <= 1'b0;
    end
  end

  // interrupt mask
  // gates the output only, never the flags
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      int_mask <= vd_pkg::INT_MASK_RESET;
    else if (wr_mask && w_strb[0])
      int_mask <= w_data[vd_pkg::INT_W-1:0];
  end

  // level interrupt from unmasked flags
  // trails the status by one cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(int_status & int_mask);
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // control readback image
  // reserved bits read one, unused ones zero
  always_comb
  begin
    ctrl_rd                                          = '0;
    ctrl_rd[vd_pkg::EN_BIT]                          = ctrl.enable;
    ctrl_rd[vd_pkg::SIDL_BIT]                        = ctrl.stop_in_idle;
    ctrl_rd[vd_pkg::DIR_BIT]                         = ctrl.dir_up;
    ctrl_rd[vd_pkg::RSV_A_BIT]                       = 1'b1;
    ctrl_rd[vd_pkg::RSV_B_BIT]                       = 1'b1;
    ctrl_rd[vd_pkg::LIVE_BIT]                        = live;
    ctrl_rd[vd_pkg::LIMIT_LSB +: vd_pkg::LIMIT_W]    = ctrl.limit;
  end

  // address decode for reads
  // unmapped reads give zero and an error
  always_comb
  begin
    next_rdata = '0;
    next_rresp = vd_pkg::RESP_OKAY;
    case (s_axi_araddr_in)
      vd_pkg::CTRL_OFFSET:
        next_rdata[vd_pkg::CTRL_W-1:0] = ctrl_rd;
      vd_pkg::INT_STATUS_OFFSET:
        next_rdata[vd_pkg::INT_W-1:0] = int_status;
      vd_pkg::INT_MASK_OFFSET:
        next_rdata[vd_pkg::INT_W-1:0] = int_mask;
      default:
        next_rresp = vd_pkg::RESP_SLVERR;
    endcase
  end

  // one read in flight
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // read data registered, one per request
  // rdata and rresp stand until rready
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= '0;
      s_axi_rresp_out  <= vd_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= next_rdata;
      s_axi_rresp_out  <= next_rresp;
    end
    else if (s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> tb/vd_comparator_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// supply comparator and reference model
// ----------------------------------------
module vd_comparator_model
(
  input  wire logic               sys_clk_in, // system clock
  input  wire vd_pkg::vd_analog_s ana_in,     // comparator setup
  input  wire logic [1:0]         rel_in,     // 0 below, 1 at, 2 above trip
  output logic                    above_out,  // at or above trip
  output logic                    below_out   // at or below trip
);
  // unpowered comparator holds both outputs low
  always_ff @(posedge sys_clk_in)
  begin
    above_out <= ana_in.power & (rel_in != 2'h0);
    below_out <= ana_in.power & (rel_in != 2'h2);
  end
endmodule

`default_nettype wire

// >>> tb/vd_detect_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// port checker for the detect block
// ----------------------------------------
module vd_detect_ctrl_sva
(
  input wire logic               sys_clk_in,        // system clock
  input wire logic               rst_in,            // sync reset
  input wire logic               s_axi_awvalid_in,  // aw valid
  input wire logic               s_axi_awready_out, // aw ready
  input wire logic               s_axi_wvalid_in,   // w valid
  input wire logic               s_axi_wready_out,  // w ready
  input wire logic [1:0]         s_axi_bresp_out,   // write response
  input wire logic               s_axi_bvalid_out,  // b valid
  input wire logic               s_axi_bready_in,   // b ready
  input wire logic               s_axi_arvalid_in,  // ar valid
  input wire logic               s_axi_arready_out, // ar ready
  input wire logic [31:0]        s_axi_rdata_out,   // read data
  input wire logic               s_axi_rvalid_out,  // r valid
  input wire logic               s_axi_rready_in,   // r ready
  input wire logic               supply_above_in,   // at or above
  input wire logic               supply_below_in,   // at or below
  input wire vd_pkg::vd_analog_s analog_ctrl_out,   // comparator setup
  input wire logic               live_event_out     // live status
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  // bus handshakes
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_refuse_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken during response");

  // detector behaviour
  a_live_powered: assert property (live_event_out |-> analog_ctrl_out.power)
    else $error("event while unpowered");
  a_live_cause: assert property (live_event_out |-> $past(supply_above_in)
    || $past(supply_below_in)) else $error("event without comparator");
  a_ext_select: assert property (analog_ctrl_out.ext_select
    == (analog_ctrl_out.level == 4'hF)) else $error("external select wrong");
  a_reserved_off: assert property (analog_ctrl_out.power
    |-> analog_ctrl_out.level >= 4'h5) else $error("reserved code powered");
endmodule

bind vd_detect_ctrl vd_detect_ctrl_sva u_sva (.sys_clk_in, .rst_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .supply_above_in,
  .supply_below_in, .analog_ctrl_out, .live_event_out);

`default_nettype wire

// >>> tb/vd_detect_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module vd_detect_ctrl_tb;
  logic               clk = 1'h0;
  logic               rst = 1'h1;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]        wdata = 32'h0, rdata;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic               arvalid = 1'h0, rready = 1'h0, idle = 1'h0;
  logic               awready, wready, bvalid, arready, rvalid, above, below, live, irq;
  logic [1:0]         bresp, rresp, rel = 2'h0;
  vd_pkg::vd_analog_s ana;
  int                 n_errors = 0;
  int                 checks = 0;
  localparam logic [7:0] CT = vd_pkg::CTRL_OFFSET;
  localparam logic [7:0] ST = vd_pkg::INT_STATUS_OFFSET;
  localparam logic [1:0] OK = vd_pkg::RESP_OKAY;

  always #12.5 clk = ~clk;

  vd_detect_ctrl dut (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .idle_mode_in(idle), .supply_above_in(above),
    .supply_below_in(below), .analog_ctrl_out(ana), .live_event_out(live),
    .irq_out(irq));

  vd_comparator_model u_cmp (.sys_clk_in(clk), .ana_in(ana), .rel_in(rel),
    .above_out(above), .below_out(below));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    tb = 1'h0;
    for (int n = 0; n < 50 && !tb; n++)
    begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    chk({29'h0, tb, r}, {29'h0, 1'h1, er});
  endtask

  // bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    tr = 1'h0;
    for (int n = 0; n < 50 && !tr; n++)
    begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    chk(d, e);
    chk({29'h0, tr, r}, {29'h0, 1'h1, er});
  endtask

  task automatic wait_live(input logic e);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (live !== e && n < 20);
    chk({31'h0, live}, {31'h0, e});
  endtask

  // configure while off, then enable and let it settle
  task automatic en(input logic [15:0] cfg);
    wr(CT, {16'h0, cfg & 16'h7FFF}, OK);
    wr(CT, {16'h0, cfg | 16'h8000}, OK);
    repeat (vd_pkg::SETTLE_CYCLES + 4) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(CT, 32'h0600, OK);
    rd(ST, 32'h1, OK);
    rd(vd_pkg::INT_MASK_OFFSET, 32'h0, OK);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_fields();
    wr(CT, 32'h76F7, OK);
    rd(CT, 32'h2607, OK);
    wr(ST, 32'h1, OK);
    rd(ST, 32'h0, OK);
    rel <= 2'h2;
    repeat (20) @(posedge clk);
    rd(ST, 32'h0, OK);
    chk({31'h0, live}, 32'h0);
  endtask

  task automatic t_event_up();
    rel <= 2'h0;
    en(16'h0807);
    chk(32'(ana), 32'h27);
    rd(ST, 32'h2, OK);
    wr(ST, 32'h3, OK);
    rd(ST, 32'h0, OK);
    wr(vd_pkg::INT_MASK_OFFSET, 32'h1, OK);
    rel <= 2'h2;
    wait_live(1'h1);
    rd(CT, 32'h8F07, OK);
    chk({31'h0, irq}, 32'h1);
    wr(ST, 32'h1, OK);
    rd(ST, 32'h1, OK);
    rel <= 2'h1;
    repeat (4) @(negedge clk);
    chk({31'h0, live}, 32'h1);
    @(posedge clk);
    rel <= 2'h0;
    wait_live(1'h0);
    rd(ST, 32'h1, OK);
    wr(ST, 32'h1, OK);
    rd(ST, 32'h0, OK);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_event_down();
    en(16'h000F);
    chk(32'(ana), 32'h3F);
    wait_live(1'h1);
    @(posedge clk);
    rel <= 2'h2;
    wait_live(1'h0);
  endtask

  task automatic t_idle();
    @(posedge clk);
    rel <= 2'h0;
    idle <= 1'h1;
    repeat (5) @(negedge clk);
    chk({31'h0, live}, 32'h1);
    en(16'h200F);
    chk({31'h0, ana.power, live}, 32'h0);
    idle <= 1'h0;
    repeat (vd_pkg::SETTLE_CYCLES + 4) @(posedge clk);
    wait_live(1'h1);
  endtask

  task automatic t_codes();
    for (int c = 4; c < 16; c++)
    begin
      wr(CT, c, OK);
      wr(CT, 32'h8000 | c, OK);
      repeat (3) @(negedge clk);
      chk({ana.power, ana.ext_select}, {c > 4, c == 15});
    end
  endtask

  task automatic t_unmapped();
    wr(CT, 32'h0, OK);
    wr(8'h0C, 32'hFFFF, vd_pkg::RESP_SLVERR);
    rd(8'h0C, 32'h0, vd_pkg::RESP_SLVERR);
    rd(CT, 32'h0600, OK);
  endtask

  // ----------------------------------------
  // verdict, sequence and watchdog
  // ----------------------------------------
  task automatic results();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_fields();
    t_event_up();
    t_event_down();
    t_idle();
    t_codes();
    t_unmapped();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule

`default_nettype wire
